// *** src/pec_top.sv ***
// Summary of operation
// - every pin of every port may detect change
// - interrupt only while master enable set
// - flags still set when master enable clear
// - per-pin rising detector with enable bit
// - per-pin falling detector with enable bit
// - both enables flag both edge directions
// - enabled edge sets flag, requests interrupt
// - summary flag is OR of pin flags
// - software clears flags by writing zero
// - edge during clearing write keeps flag set
// - change event wakes from sleep if enabled
// - flags updated before first instruction after wake
// - rise enables eight bits, reset zero
// - fall enables eight bits, reset zero
// - single-pin port implements only bit three
// - threshold select picks schmitt or ttl input
// - flags read/write, hardware set, reset zero
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "pec_cfg.svh"

module pec_top #(
  parameter int NPORT = 3
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [8*NPORT-1:0] PORT_PINS,
  input wire logic SINGLE_PIN_SCHMITT,
  input wire logic SINGLE_PIN_TTL,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CHANGE_IRQ,
  output logic WAKE_REQ
);
  localparam int NP = NPORT + 1;

  pec_pkg::pec_port_regs_t regs [NP];
  pec_pkg::pec_port_regs_t next_regs [NP];
  logic change_irq_master_enable;
  logic single_port_threshold_reg;
  logic [8*NP-1:0] sync1, sync2, prev;
  logic [8*NP-1:0] pin_raw;
  logic [1:0] single_sync1, single_sync2;
  logic [8*NP-1:0] cur_all;
  logic [7:0] impl_mask [NP];
  logic [7:0] rise_hit [NP];
  logic [7:0] fall_hit [NP];
  logic [NP-1:0] port_any;
  logic change_irq_summary_flag;
  logic [31:0] rd_word;
  logic rd_hit;
  logic apb_wr;
  pec_pkg::pec_apb_req_t req;

  // decodes a port-relative offset into its register kind
  function automatic pec_pkg::pec_reg_kind_t reg_kind(input logic [11:0] a, input logic [11:0] base);
    if (a == base) begin
      reg_kind = pec_pkg::PEC_REG_RISE;
    end else if (a == base + 12'h004) begin
      reg_kind = pec_pkg::PEC_REG_FALL;
    end else if (a == base + 12'h008) begin
      reg_kind = pec_pkg::PEC_REG_FLAG;
    end else begin
      reg_kind = pec_pkg::PEC_REG_NONE;
    end
  endfunction

  assign req = '{addr: PADDR, write: PWRITE, wdata: PWDATA};
  assign apb_wr = PSEL && PENABLE && req.write;

  // both threshold views are synchronised; selection happens after the flops
  wire single_pin = single_port_threshold_reg ? single_sync2[1] : single_sync2[0];
  assign pin_raw = {8'h00, PORT_PINS};
  assign cur_all = {4'h0, single_pin, 3'h0, sync2[8*NPORT-1:0]};

  // two flops before any logic reads the pins
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1 <= '0;
      sync2 <= '0;
      single_sync1 <= 2'h0;
      single_sync2 <= 2'h0;
      prev <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      single_sync1 <= {SINGLE_PIN_SCHMITT, SINGLE_PIN_TTL};
      single_sync2 <= single_sync1;
      prev <= cur_all;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : gen_port
      wire [11:0] base = (g == NPORT) ? `PEC_OFF_E_RISE : (`PEC_OFF_A_RISE + 12'(g * 16));
      wire pec_pkg::pec_reg_kind_t kind = reg_kind(req.addr, base);
      wire [7:0] cur = cur_all[8*g+7:8*g];
      wire [7:0] old = prev[8*g+7:8*g];
      assign impl_mask[g] = (g == NPORT) ? `PEC_SINGLE_PIN_MASK : 8'hff;
      assign rise_hit[g] = regs[g].rise & cur & ~old;
      assign fall_hit[g] = regs[g].fall & ~cur & old;
      assign port_any[g] = |regs[g].flag;

      always_comb begin
        next_regs[g] = regs[g];
        if (apb_wr && kind == pec_pkg::PEC_REG_RISE) begin
          next_regs[g].rise = req.wdata[7:0] & impl_mask[g];
        end
        if (apb_wr && kind == pec_pkg::PEC_REG_FALL) begin
          next_regs[g].fall = req.wdata[7:0] & impl_mask[g];
        end
        if (apb_wr && kind == pec_pkg::PEC_REG_FLAG) begin
          next_regs[g].flag = req.wdata[7:0] & impl_mask[g];
        end
        // a new edge wins over a clearing write
        next_regs[g].flag = next_regs[g].flag | rise_hit[g] | fall_hit[g];
      end

      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          regs[g] <= '{rise: `PEC_RST_EDGE_EN, fall: `PEC_RST_EDGE_EN, flag: `PEC_RST_FLAG};
        end else begin
          regs[g] <= next_regs[g];
        end
      end
    end
  endgenerate

  assign change_irq_summary_flag = |port_any;

  // read mux
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b0;
    if (req.addr == `PEC_OFF_CTRL) begin
      rd_hit = 1'b1;
      rd_word[`PEC_CTRL_MASTER_BIT] = change_irq_master_enable;
      rd_word[`PEC_CTRL_SUMMARY_BIT] = change_irq_summary_flag;
    end else if (req.addr == `PEC_OFF_E_THRESH) begin
      rd_hit = 1'b1;
      rd_word[`PEC_SINGLE_PIN_BIT] = single_port_threshold_reg;
    end
    for (int i = 0; i < NP; i++) begin
      if (reg_kind(req.addr, (i == NPORT) ? `PEC_OFF_E_RISE : (`PEC_OFF_A_RISE + 12'(i * 16)))
          == pec_pkg::PEC_REG_RISE) begin
        rd_hit = 1'b1;
        rd_word[7:0] = regs[i].rise;
      end
      if (reg_kind(req.addr, (i == NPORT) ? `PEC_OFF_E_RISE : (`PEC_OFF_A_RISE + 12'(i * 16)))
          == pec_pkg::PEC_REG_FALL) begin
        rd_hit = 1'b1;
        rd_word[7:0] = regs[i].fall;
      end
      if (reg_kind(req.addr, (i == NPORT) ? `PEC_OFF_E_RISE : (`PEC_OFF_A_RISE + 12'(i * 16)))
          == pec_pkg::PEC_REG_FLAG) begin
        rd_hit = 1'b1;
        rd_word[7:0] = regs[i].flag;
      end
    end
  end

  // control, threshold and zero-wait-state apb answer
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      change_irq_master_enable <= 1'b0;
      single_port_threshold_reg <= 1'b1;
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      if (apb_wr && req.addr == `PEC_OFF_CTRL) begin
        change_irq_master_enable <= req.wdata[`PEC_CTRL_MASTER_BIT];
      end
      if (apb_wr && req.addr == `PEC_OFF_E_THRESH) begin
        single_port_threshold_reg <= req.wdata[`PEC_SINGLE_PIN_BIT];
      end
      PREADY <= PSEL && !PENABLE;
      PRDATA <= rd_word;
      PSLVERR <= PSEL && !PENABLE && !rd_hit;
    end
  end

  // irq follows the flags one cycle later; flags are already set when the core wakes
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CHANGE_IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      CHANGE_IRQ <= change_irq_master_enable & change_irq_summary_flag;
      WAKE_REQ <= change_irq_master_enable & change_irq_summary_flag;
    end
  end
endmodule

// *** src/pec_cfg.svh ***
`ifndef PEC_CFG_SVH
`define PEC_CFG_SVH
// register byte offsets (word aligned)
`define PEC_OFF_CTRL 12'h000
`define PEC_OFF_A_RISE 12'h010
`define PEC_OFF_A_FALL 12'h014
`define PEC_OFF_A_FLAG 12'h018
`define PEC_OFF_B_RISE 12'h020
`define PEC_OFF_B_FALL 12'h024
`define PEC_OFF_B_FLAG 12'h028
`define PEC_OFF_C_RISE 12'h030
`define PEC_OFF_C_FALL 12'h034
`define PEC_OFF_C_FLAG 12'h038
`define PEC_OFF_E_RISE 12'h040
`define PEC_OFF_E_FALL 12'h044
`define PEC_OFF_E_FLAG 12'h048
`define PEC_OFF_E_THRESH 12'h04c
// control register fields
`define PEC_CTRL_MASTER_BIT 3
`define PEC_CTRL_SUMMARY_BIT 0
// single-pin port
`define PEC_SINGLE_PIN_BIT 3
`define PEC_SINGLE_PIN_MASK 8'h08
// reset values
`define PEC_RST_EDGE_EN 8'h00
`define PEC_RST_FLAG 8'h00
`define PEC_RST_THRESH 8'h08
`endif

// *** src/pec_pkg.sv ***
package pec_pkg;
  typedef enum logic [1:0] {
    PEC_REG_RISE = 2'h0,
    PEC_REG_FALL = 2'h1,
    PEC_REG_FLAG = 2'h2,
    PEC_REG_NONE = 2'h3
  } pec_reg_kind_t;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flag;
  } pec_port_regs_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } pec_apb_req_t;
endpackage

// *** testbench/pec_monitor.sv ***
`timescale 1ns/1ps
module pec_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CHANGE_IRQ,
  input wire logic WAKE_REQ
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  wire wr = PSEL && PENABLE && PWRITE && PREADY;
  logic master;
  // shadow of the master enable, the checker cannot see inside
  always_ff @(posedge CLK or posedge SYS_RST)
    if (SYS_RST) master <= 1'b0;
    else if (wr && PADDR == 12'h000) master <= PWDATA[3];
  a_wake_follows_irq: assert property (WAKE_REQ == CHANGE_IRQ) else $error("wake differs");
  a_irq_needs_master: assert property (CHANGE_IRQ |-> $past(master)) else $error("irq unmasked");
  a_irq_sticks: assert property (CHANGE_IRQ && !wr && !$past(wr) |=> CHANGE_IRQ) else $error("irq lost");
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("long ready");
  a_err_with_ready: assert property (PSLVERR |-> PREADY && PENABLE) else $error("stray error");
  a_upper_bits_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0) else $error("upper bits");
  a_single_pin_bits: assert property (PREADY && !PWRITE && PADDR[11:4] == 8'h04 |->
    PRDATA[7:0] == {4'h0, PRDATA[3], 3'h0}) else $error("single pin bits");
  cover property ($rose(CHANGE_IRQ));
  cover property ($fell(CHANGE_IRQ));
  cover property (PSLVERR);
endmodule

bind pec_top pec_monitor mon_u (.*);

// *** testbench/pec_pin_model.sv ***
`timescale 1ns/1ps
module pec_pin_model (
  input wire logic CLK,
  input wire logic [25:0] lvl,
  output logic [23:0] PORT_PINS,
  output logic SINGLE_PIN_SCHMITT,
  output logic SINGLE_PIN_TTL
);
  // two views of the single pin may differ so the threshold choice shows
  initial {SINGLE_PIN_TTL, SINGLE_PIN_SCHMITT, PORT_PINS} = 26'h0;
  always @(posedge CLK) {SINGLE_PIN_TTL, SINGLE_PIN_SCHMITT, PORT_PINS} <= lvl;
endmodule

// *** testbench/pin_edge_change_interrupt_bench.sv ***
`timescale 1ns/1ps
module pin_edge_change_interrupt_bench;
  logic CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, r, f;
  logic PREADY, PSLVERR, CHANGE_IRQ, WAKE_REQ, SINGLE_PIN_SCHMITT, SINGLE_PIN_TTL, er, t, m, any;
  logic [23:0] PORT_PINS;
  logic [25:0] lvl = 26'h0, o, n;
  logic [7:0] x;
  int n_errors = 0, num_checks = 0;
  always #10 CLK = ~CLK;
  pec_top dut_u (.*);
  pec_pin_model pins_u (.*);
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  function automatic logic [7:0] pinb(logic [25:0] l, int p);
    return p == 3 ? {4'h0, t ? l[24] : l[25], 3'h0} : l[8*p+:8];
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000 n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h64cd6ecc));
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 12'(16 + 4 * i + i / 3 * 4), 32'h0);
      chk("reset", rd, 32'h0);
    end
    apb(1'b0, 12'h04c, 32'h0);
    chk("threshold", rd, 32'h8);
    apb(1'b1, 12'h004, 32'hff);
    chk("slverr", 32'(er), 32'h1);
    repeat (20) begin
      r = $urandom;
      f = $urandom;
      o = 26'($urandom);
      n = 26'($urandom);
      {m, t} = 2'($urandom);
      apb(1'b1, 12'h000, {28'h0, m, 3'h0});
      apb(1'b1, 12'h04c, {28'h0, t, 3'h0});
      for (int i = 0; i < 8; i++) begin
        x = i[0] ? f[i/2*8+:8] : r[i/2*8+:8];
        apb(1'b1, 12'(16 + 8 * i - 4 * i[0]), {24'h0, x});
        apb(1'b0, PADDR, 32'h0);
        chk("enable", rd, {24'h0, x & (i > 5 ? 8'h08 : 8'hff)});
      end
      // settle first: a threshold change may itself look like an edge
      lvl <= o;
      repeat (6) @(posedge CLK);
      for (int p = 0; p < 4; p++) apb(1'b1, 12'(24 + 16 * p), 32'h0);
      repeat (3) @(posedge CLK);
      chk("irq cleared", 32'(CHANGE_IRQ), 32'h0);
      lvl <= n;
      repeat (6) @(posedge CLK);
      any = 1'b0;
      for (int p = 0; p < 4; p++) begin
        x = (~pinb(o, p) & pinb(n, p) & r[8*p+:8]) | (pinb(o, p) & ~pinb(n, p) & f[8*p+:8]);
        apb(1'b0, 12'(24 + 16 * p), 32'h0);
        chk("flag", rd, {24'h0, x});
        any |= |x;
      end
      chk("irq", 32'(CHANGE_IRQ), 32'(m & any));
      chk("wake", 32'(WAKE_REQ), 32'(m & any));
      apb(1'b0, 12'h000, 32'h0);
      chk("summary", rd & 32'h9, {28'h0, m, 2'h0, any});
    end
    apb(1'b1, 12'h010, 32'h1);
    lvl <= 26'h0;
    repeat (6) @(posedge CLK);
    apb(1'b1, 12'h018, 32'h0);
    // edge lands on the very edge that completes the clearing write
    lvl <= 26'h1;
    @(posedge CLK);
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk("set wins", rd, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    apb(1'b1, 12'h018, rd & (rd ^ 32'hff));
    apb(1'b0, 12'h018, 32'h0);
    chk("masked clear", rd, 32'h0);
    tally_and_finish();
  end
endmodule
